// ### hw/pvf_pack.v
// Packet assembler: packs the vector fields into one 32-bit word.
// Assumes fields already checked and length already reduced by one.
`timescale 1ns/1ps
`include "pvf_regs.vh"

module pvf_pack (
    // Vector fields
    input  wire [6:0]  word_pos,
    input  wire        err_flag,
    input  wire [1:0]  phase,
    input  wire [2:0]  vtype,
    input  wire [3:0]  check_bits,
    input  wire [6:0]  len_m1,
    input  wire [6:0]  start_word,
    // Packed word, byte 3 in the top bits
    output wire [31:0] packet
);

    // ------------------------------------------------------------------
    // Layout selection
    // ------------------------------------------------------------------
    wire       numeric;
    wire [7:0] byte3;
    wire [7:0] byte2;
    wire [7:0] byte1;
    wire [7:0] byte0;

    // Numeric kinds carry check bits and a 3-bit length
    assign numeric = (vtype == `PVF_TYPE_NUM_STD) ||
                     (vtype == `PVF_TYPE_NUM_SPEC) ||
                     (vtype == `PVF_TYPE_NUM_NMBR);

    assign byte3 = {1'b0, word_pos};
    assign byte2 = {err_flag, phase, 2'b00, vtype};
    assign byte1 = numeric ? {2'b00, check_bits, len_m1[2:1]}
                           : {2'b00, len_m1[6:1]};
    assign byte0 = {len_m1[0], start_word};

    assign packet = {byte3, byte2, byte1, byte0};

endmodule

// ### hw/pvf_regs.vh
// Constants for the vector packet formatter: register map, field
// positions, reset values, type codes and range limits.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef PVF_REGS_VH
`define PVF_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PVF_ADDR_CTRL      8'h00
`define PVF_ADDR_VECTOR    8'h04
`define PVF_ADDR_MSGSTART  8'h08
`define PVF_ADDR_STATUS    8'h0c
`define PVF_ADDR_PACKET    8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PVF_CTRL_SEND      0
`define PVF_CTRL_LONG      1

// ----------------------------------------------------------------------
// Vector register fields
// ----------------------------------------------------------------------
`define PVF_VEC_POS_LSB    0
`define PVF_VEC_POS_MSB    6
`define PVF_VEC_PH_LSB     8
`define PVF_VEC_PH_MSB     9
`define PVF_VEC_TYPE_LSB   12
`define PVF_VEC_TYPE_MSB   14
`define PVF_VEC_CHK_LSB    16
`define PVF_VEC_CHK_MSB    19
`define PVF_VEC_CNT_LSB    20
`define PVF_VEC_CNT_MSB    26

// ----------------------------------------------------------------------
// Message start register fields
// ----------------------------------------------------------------------
`define PVF_MS_START_LSB   0
`define PVF_MS_START_MSB   6
`define PVF_MS_BITERR      8
`define PVF_MS_CHKFAIL     9

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define PVF_ST_PENDING     0
`define PVF_ST_ALLFRAME    1
`define PVF_ST_INHIBIT     2
`define PVF_ST_BUSY        3
`define PVF_ST_FIRST_LSB   8
`define PVF_ST_FIRST_MSB   14

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PVF_RST_WORD       32'h0000_0000
`define PVF_RST_POS        7'h00
`define PVF_RESP_OKAY      2'h0
`define PVF_RESP_SLVERR    2'h2

// ----------------------------------------------------------------------
// Vector type codes
// ----------------------------------------------------------------------
`define PVF_TYPE_SECURE    3'h0
`define PVF_TYPE_NUM_STD   3'h3
`define PVF_TYPE_NUM_SPEC  3'h4
`define PVF_TYPE_ALPHA     3'h5
`define PVF_TYPE_HEXBIN    3'h6
`define PVF_TYPE_NUM_NMBR  3'h7

// ----------------------------------------------------------------------
// Value ranges
// ----------------------------------------------------------------------
`define PVF_POS_MIN        7'h02
`define PVF_POS_MAX        7'h57
`define PVF_START_MIN      7'h03
`define PVF_START_MAX      7'h57
`define PVF_CNT_MIN        7'h01
`define PVF_CNT_NUM_MAX    7'h08
`define PVF_CNT_ALN_MAX    7'h55
`define PVF_ONE7           7'h01

// ----------------------------------------------------------------------
// Link shifter
// ----------------------------------------------------------------------
`define PVF_BITS_LAST      5'h1f
`define PVF_BITS_ZERO      5'h00

`endif

// ### hw/pvf_top.v
// Vector packet formatter: AXI4-Lite registers, packet build, serial out.
// Assumes mclk at 125 MHz; link clock and select arrive asynchronously.
//
// Summary of operation
// - Byte 3 is zero then word position; byte 2 error, phase, type.
// - Numeric byte 1 holds check bits and length top bits; byte 0 rest.
// - Word position field reports vector location, 2 to 87.
// - Error flag on bit errors, failed check, or invalid value.
// - Phase field encodes a to d as 0 to 3.
// - Length field holds word count minus one.
// - Long address first message word follows the vector word.
// - Start field gives message start word, 3 to 87.
// - Long address start field points to second message word.
// - Type 011 marks a standard numeric vector.
// - Type 100 marks special-format numeric; host formats it.
// - Type 111 marks a numbered numeric vector.
// - Non-numeric packets carry 7-bit length across bytes 1 and 0.
// - Types 000 secure, 101 alphanumeric, 110 hex/binary.
// - Bit errors set error flag and inhibit message words.
// - Non-numeric vector enters all-frame mode until host disables.
`timescale 1ns/1ps
`include "pvf_regs.vh"

module pvf_top (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst,
    // AXI4-Lite write address
    input  wire [7:0]  s_awaddr,
    input  wire        s_awvalid,
    output reg         s_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_wdata,
    input  wire [3:0]  s_wstrb,
    input  wire        s_wvalid,
    output reg         s_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_bresp,
    output reg         s_bvalid,
    input  wire        s_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_araddr,
    input  wire        s_arvalid,
    output reg         s_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_rdata,
    output reg  [1:0]  s_rresp,
    output reg         s_rvalid,
    input  wire        s_rready,
    // Serial link to host
    input  wire        link_sclk,
    input  wire        link_sel_n,
    output reg         link_sdo,
    // Host packet decoder and message word path
    input  wire        all_frame_off,
    output reg         all_frame_mode,
    output reg         msg_inhibit
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [31:0] ctrl_reg;
    reg  [31:0] vec_reg;
    reg  [31:0] ms_reg;
    reg  [31:0] tx_word;
    reg         pending;
    reg  [6:0]  first_msg_pos;
    reg         sclk_s1;
    reg         sclk_s2;
    reg         sclk_s3;
    reg         sel_s1;
    reg         sel_s2;
    reg         sel_s3;
    reg  [31:0] shift_reg;
    reg  [4:0]  bit_cnt;
    reg         busy;
    reg         done_all;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;

    wire        aw_take;
    wire        w_take;
    wire        ar_take;
    wire        wr_fire;
    wire [31:0] wmask;
    wire [6:0]  f_pos;
    wire [1:0]  f_phase;
    wire [2:0]  f_type;
    wire [3:0]  f_check;
    wire [6:0]  f_count;
    wire [6:0]  f_start;
    wire        f_biterr;
    wire        f_chkfail;
    wire        is_numeric;
    wire        type_ok;
    wire        value_bad;
    wire        err_flag;
    wire [6:0]  len_m1;
    wire [31:0] packet;
    wire        send_cmd;
    wire        sclk_fall;
    wire        sel_fall;
    wire        sel_rise;
    wire        sel_act;

    // ------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------
    assign aw_take = s_awvalid & s_awready;
    assign w_take  = s_wvalid & s_wready;
    assign ar_take = s_arvalid & s_arready;
    assign wr_fire = aw_held & w_held & ~s_bvalid;
    assign wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Write address and data capture, either order
    always @(posedge mclk) begin
        if (rst) begin
            aw_held   <= 1'b0;
            aw_addr   <= 8'h00;
            w_held    <= 1'b0;
            w_data    <= `PVF_RST_WORD;
            w_strb    <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_held <= 1'b0;
            end else if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (wr_fire) begin
                w_held <= 1'b0;
            end else if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            s_awready <= ~(aw_take | (aw_held & ~wr_fire));
            s_wready  <= ~(w_take | (w_held & ~wr_fire));
        end
    end

    // Write response, error on unmapped or read-only address
    always @(posedge mclk) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `PVF_RESP_OKAY;
        end else if (wr_fire) begin
            s_bvalid <= 1'b1;
            if ((aw_addr == `PVF_ADDR_CTRL) ||
                (aw_addr == `PVF_ADDR_VECTOR) ||
                (aw_addr == `PVF_ADDR_MSGSTART)) begin
                s_bresp <= `PVF_RESP_OKAY;
            end else begin
                s_bresp <= `PVF_RESP_SLVERR;
            end
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Byte-lane merge into writable registers
    always @(posedge mclk) begin
        if (rst) begin
            ctrl_reg <= `PVF_RST_WORD;
            vec_reg  <= `PVF_RST_WORD;
            ms_reg   <= `PVF_RST_WORD;
        end else if (wr_fire) begin
            if (aw_addr == `PVF_ADDR_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~wmask) | (w_data & wmask);
            end
            if (aw_addr == `PVF_ADDR_VECTOR) begin
                vec_reg <= (vec_reg & ~wmask) | (w_data & wmask);
            end
            if (aw_addr == `PVF_ADDR_MSGSTART) begin
                ms_reg <= (ms_reg & ~wmask) | (w_data & wmask);
            end
        end
    end

    // Send strobe: a one written to the send bit of control
    assign send_cmd = wr_fire & (aw_addr == `PVF_ADDR_CTRL) &
                      w_strb[0] & w_data[`PVF_CTRL_SEND];

    // ------------------------------------------------------------------
    // Field extraction and checks
    // ------------------------------------------------------------------
    // vector word position
    assign f_pos     = vec_reg[`PVF_VEC_POS_MSB:`PVF_VEC_POS_LSB];
    assign f_phase   = vec_reg[`PVF_VEC_PH_MSB:`PVF_VEC_PH_LSB];
    assign f_type    = vec_reg[`PVF_VEC_TYPE_MSB:`PVF_VEC_TYPE_LSB];
    assign f_check   = vec_reg[`PVF_VEC_CHK_MSB:`PVF_VEC_CHK_LSB];
    assign f_count   = vec_reg[`PVF_VEC_CNT_MSB:`PVF_VEC_CNT_LSB];
    assign f_start   = ms_reg[`PVF_MS_START_MSB:`PVF_MS_START_LSB];
    assign f_biterr  = ms_reg[`PVF_MS_BITERR];
    assign f_chkfail = ms_reg[`PVF_MS_CHKFAIL];

    assign is_numeric = (f_type == `PVF_TYPE_NUM_STD) ||
                        (f_type == `PVF_TYPE_NUM_SPEC) ||
                        (f_type == `PVF_TYPE_NUM_NMBR);
    assign type_ok = is_numeric ||
                     (f_type == `PVF_TYPE_SECURE) ||
                     (f_type == `PVF_TYPE_ALPHA) ||
                     (f_type == `PVF_TYPE_HEXBIN);

    // Values outside their documented ranges count as invalid
    assign value_bad = ~type_ok ||
                       (f_pos < `PVF_POS_MIN) ||
                       (f_pos > `PVF_POS_MAX) ||
                       (f_start < `PVF_START_MIN) ||
                       (f_start > `PVF_START_MAX) ||
                       (f_count < `PVF_CNT_MIN) ||
                       (is_numeric && (f_count > `PVF_CNT_NUM_MAX)) ||
                       (!is_numeric && (f_count > `PVF_CNT_ALN_MAX));

    assign err_flag = f_biterr | f_chkfail | value_bad;

    assign len_m1 = f_count - `PVF_ONE7;

    // Packet assembly
    pvf_pack u_pack (
        .word_pos   (f_pos),
        .err_flag   (err_flag),
        .phase      (f_phase),
        .vtype      (f_type),
        .check_bits (f_check),
        .len_m1     (len_m1),
        .start_word (f_start),
        .packet     (packet)
    );

    // ------------------------------------------------------------------
    // Packet latch and vector side effects
    // ------------------------------------------------------------------
    // Latch packet on send; shifter completion clears pending
    always @(posedge mclk) begin
        if (rst) begin
            tx_word       <= `PVF_RST_WORD;
            pending       <= 1'b0;
            msg_inhibit   <= 1'b0;
            first_msg_pos <= `PVF_RST_POS;
        end else if (send_cmd) begin
            tx_word     <= packet;
            pending     <= 1'b1;
            // no message words after bit errors
            msg_inhibit <= f_biterr;
            // long address first word follows vector
            if (ctrl_reg[`PVF_CTRL_LONG]) begin
                first_msg_pos <= f_pos + `PVF_ONE7;
            end else begin
                first_msg_pos <= f_start;
            end
        end else if (done_all) begin
            pending <= 1'b0;
        end
    end

    // all-frame mode set on non-numeric, set wins
    always @(posedge mclk) begin
        if (rst) begin
            all_frame_mode <= 1'b0;
        end else if (send_cmd && type_ok && !is_numeric) begin
            all_frame_mode <= 1'b1;
        end else if (all_frame_off) begin
            all_frame_mode <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Link input synchronisers
    // ------------------------------------------------------------------
    // Two stages, third only for edge finding
    always @(posedge mclk) begin
        if (rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            sel_s1  <= 1'b1;
            sel_s2  <= 1'b1;
            sel_s3  <= 1'b1;
        end else begin
            sclk_s1 <= link_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sel_s1  <= link_sel_n;
            sel_s2  <= sel_s1;
            sel_s3  <= sel_s2;
        end
    end

    assign sclk_fall = sclk_s3 & ~sclk_s2;
    assign sel_fall  = sel_s3 & ~sel_s2;
    assign sel_rise  = ~sel_s3 & sel_s2;
    assign sel_act   = ~sel_s2;

    // ------------------------------------------------------------------
    // Serial shifter, byte 3 first, most significant bit first
    // ------------------------------------------------------------------
    // Data changes on falling link clock; host samples on rising
    always @(posedge mclk) begin
        if (rst) begin
            shift_reg <= `PVF_RST_WORD;
            bit_cnt   <= `PVF_BITS_ZERO;
            busy      <= 1'b0;
            done_all  <= 1'b0;
            link_sdo  <= 1'b0;
        end else begin
            done_all <= 1'b0;
            if (sel_fall) begin
                shift_reg <= pending ? tx_word : `PVF_RST_WORD;
                link_sdo  <= pending ? tx_word[31] : 1'b0;
                bit_cnt   <= `PVF_BITS_ZERO;
                busy      <= pending;
            end else if (sel_rise) begin
                busy     <= 1'b0;
                link_sdo <= 1'b0;
            end else if (sel_act && sclk_fall && busy) begin
                if (bit_cnt == `PVF_BITS_LAST) begin
                    busy     <= 1'b0;
                    done_all <= 1'b1;
                    link_sdo <= 1'b0;
                end else begin
                    shift_reg <= {shift_reg[30:0], 1'b0};
                    link_sdo  <= shift_reg[30];
                    bit_cnt   <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read mux, error on unmapped address
    always @* begin
        next_rdata = `PVF_RST_WORD;
        next_rresp = `PVF_RESP_OKAY;
        case (s_araddr)
            `PVF_ADDR_CTRL: begin
                next_rdata = ctrl_reg;
            end
            `PVF_ADDR_VECTOR: begin
                next_rdata = vec_reg;
            end
            `PVF_ADDR_MSGSTART: begin
                next_rdata = ms_reg;
            end
            `PVF_ADDR_STATUS: begin
                next_rdata[`PVF_ST_PENDING] = pending;
                next_rdata[`PVF_ST_ALLFRAME] = all_frame_mode;
                next_rdata[`PVF_ST_INHIBIT] = msg_inhibit;
                next_rdata[`PVF_ST_BUSY] = busy;
                next_rdata[`PVF_ST_FIRST_MSB:`PVF_ST_FIRST_LSB] =
                    first_msg_pos;
            end
            `PVF_ADDR_PACKET: begin
                next_rdata = tx_word;
            end
            default: begin
                next_rresp = `PVF_RESP_SLVERR;
            end
        endcase
    end

    // Read channel, one outstanding read
    always @(posedge mclk) begin
        if (rst) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= `PVF_RST_WORD;
            s_rresp   <= `PVF_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_rvalid <= 1'b1;
                s_rdata  <= next_rdata;
                s_rresp  <= next_rresp;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
            s_arready <= ~ar_take & ~(s_rvalid & ~s_rready);
        end
    end

endmodule

// ### sim/pvf_checker.sv
// Checker: bus, link and mode relations at the formatter's ports.
// Assumes binding to pvf_top; mclk domain, rst synchronous high.
`timescale 1ns/1ps
module pvf_checker (
    // Clock and reset
    input wire        mclk,
    input wire        rst,
    // Register bus
    input wire        s_awvalid,
    input wire        s_awready,
    input wire        s_wvalid,
    input wire        s_wready,
    input wire        s_bvalid,
    input wire        s_arvalid,
    input wire        s_arready,
    input wire        s_rvalid,
    // Link and modes
    input wire        link_sel_n,
    input wire        link_sdo,
    input wire        all_frame_off,
    input wire        all_frame_mode,
    input wire        msg_inhibit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    chk_af_set_cause: assert property ($rose(all_frame_mode) |->
        !$past(s_awready) || $past(s_bvalid)) else $error("mode rose");
    chk_af_hold_on: assert property (all_frame_mode &&
        !all_frame_off |=> all_frame_mode) else $error("mode lost");
    chk_af_off_clear: assert property (all_frame_off &&
        !s_bvalid |=> !all_frame_mode) else $error("mode kept");
    chk_inhibit_cause: assert property ($changed(msg_inhibit) |->
        !$past(s_awready) || $past(s_bvalid)) else $error("inhibit");
    chk_sdo_idle_low: assert property (link_sel_n[*5] |->
        !link_sdo) else $error("sdo not idle");
    chk_first_bit_zero: assert property ($fell(link_sel_n) |->
        ##6 !link_sdo) else $error("top bit set");
    chk_b_answer_time: assert property (s_awvalid && s_awready &&
        s_wvalid && s_wready |-> ##2 s_bvalid) else $error("no bvalid");
    chk_r_answer_time: assert property (s_arvalid && s_arready
        |=> s_rvalid) else $error("no rvalid");
    chk_ar_busy_low: assert property (s_arvalid && s_arready
        |=> !s_arready) else $error("arready high");
endmodule
bind pvf_top pvf_checker chk (.mclk, .rst, .s_awvalid, .s_awready,
    .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready, .s_rvalid,
    .link_sel_n, .link_sdo, .all_frame_off, .all_frame_mode,
    .msg_inhibit);

// ### sim/pvf_host.sv
// Host model: reads one packet per select frame over the serial link.
// Assumes data shifts on falling sclk; sclk stands low outside frames.
`timescale 1ns/1ps
module pvf_host (
    // Link
    input  wire  link_sdo,
    output logic link_sclk,
    output logic link_sel_n
);
    initial begin
        link_sclk = 1'b0;
        link_sel_n = 1'b1;
    end
    // ----------------------------------------------------------------
    // Frame of 32 clocks at 80 ns, sampled on rising sclk
    // ----------------------------------------------------------------
    task automatic frame(output logic [31:0] w);
        w = 32'h0;
        #3 link_sel_n = 1'b0;
        #40;
        for (int i = 0; i < 32; i++) begin
            link_sclk = 1'b1;
            w = {w[30:0], link_sdo};
            #40 link_sclk = 1'b0;
            #40;
        end
        link_sel_n = 1'b1;
        #80;
        w = w & 32'hffe7_3fff;
    endtask
endmodule

// ### sim/test_paging_vector_packet_formatter.sv
// Testbench: sends vectors by register writes, reads packets back.
// Assumes pvf_top with the host model on its serial link.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_paging_vector_packet_formatter;
    logic        mclk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid;
    logic        s_rready, all_frame_off;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata;
    wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire         link_sclk, link_sel_n, link_sdo, all_frame_mode;
    wire         msg_inhibit;
    wire  [1:0]  s_bresp, s_rresp;
    wire  [31:0] s_rdata;
    int          n_fail, tests_run;
    logic [31:0] d;
    logic [1:0]  r;
    pvf_top dut (.mclk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .link_sclk, .link_sel_n, .link_sdo,
        .all_frame_off, .all_frame_mode, .msg_inhibit);
    pvf_host host (.link_sdo, .link_sclk, .link_sel_n);
    // Clock at 8 ns
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input [7:0] a, input [31:0] v, input [1:0] er);
        @(posedge mclk);
        s_awaddr <= a; s_wdata <= v; s_bready <= 1'b1;
        s_awvalid <= 1'b1; s_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
        `CHK(s_bresp, er)
    endtask
    task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rr);
        @(posedge mclk);
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        v = s_rdata; rr = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // One vector: build, read back, shift out, clear mode
    // ----------------------------------------------------------------
    task automatic run(input [6:0] pos, input [1:0] ph, input [2:0] ty,
        input [3:0] k, input [6:0] n, input [6:0] b, input be, cf, lg, er);
        logic [31:0] x;
        logic [6:0]  m;
        logic        num;
        m = n - 7'h01;
        num = (ty == 3'h3) || (ty == 3'h4) || (ty == 3'h7);
        x = {1'b0, pos, er, ph, 2'h0, ty, 2'h0, num ? {k, m[2:0]} : m, b};
        wr(8'h04, {5'h0, n, k, 1'b0, ty, 2'h0, ph, 1'b0, pos}, 2'h0);
        wr(8'h08, {22'h0, cf, be, 1'b0, b}, 2'h0);
        wr(8'h00, {30'h0, lg, 1'b0}, 2'h0);
        wr(8'h00, {30'h0, lg, 1'b1}, 2'h0);
        rd(8'h10, d, r);
        `CHK(d, x)
        `CHK(msg_inhibit, be)
        `CHK(all_frame_mode, !num)
        host.frame(d);
        `CHK(d, x)
        rd(8'h0c, d, r);
        `CHK(d[14:8], lg ? pos + 7'h01 : b)
        @(posedge mclk) all_frame_off <= 1'b1;
        @(posedge mclk) all_frame_off <= 1'b0;
        @(posedge mclk);
        `CHK(all_frame_mode, 1'b0)
        $display("vector type %h position %h done", ty, pos);
    endtask
    // Watchdog
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1; s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0;
        s_arvalid = 1'b0; s_rready = 1'b0; all_frame_off = 1'b0;
        s_awaddr = 8'h00; s_araddr = 8'h00; s_wdata = 32'h0;
        n_fail = 0; tests_run = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h00, d, r);
        `CHK(d, 32'h0)
        rd(8'h14, d, r);
        `CHK({r, d}, {2'h2, 32'h0})
        wr(8'h0c, 32'hffff_ffff, 2'h2);
        $display("register access done");
        run(7'h02, 2'h0, 3'h3, 4'h5, 7'h01, 7'h03, 0, 0, 0, 0);
        run(7'h57, 2'h1, 3'h4, 4'ha, 7'h08, 7'h57, 0, 0, 0, 0);
        run(7'h10, 2'h2, 3'h7, 4'hf, 7'h02, 7'h20, 0, 0, 1, 0);
        run(7'h21, 2'h3, 3'h0, 4'h0, 7'h55, 7'h30, 0, 0, 0, 0);
        run(7'h05, 2'h1, 3'h5, 4'h3, 7'h01, 7'h06, 0, 0, 1, 0);
        run(7'h30, 2'h2, 3'h6, 4'h9, 7'h28, 7'h40, 0, 0, 0, 0);
        run(7'h0a, 2'h0, 3'h3, 4'h1, 7'h02, 7'h0b, 1, 0, 0, 1);
        run(7'h0a, 2'h1, 3'h5, 4'h1, 7'h02, 7'h0b, 0, 1, 0, 1);
        run(7'h01, 2'h2, 3'h3, 4'h1, 7'h02, 7'h0b, 0, 0, 0, 1);
        run(7'h0a, 2'h3, 3'h7, 4'h1, 7'h02, 7'h58, 0, 0, 0, 1);
        run(7'h0a, 2'h0, 3'h4, 4'h1, 7'h09, 7'h0b, 0, 0, 0, 1);
        host.frame(d);
        `CHK(d, 32'h0)
        $display("empty frame done");
        stop_test;
    end
endmodule
